// file: include/eeprom_pkg.sv
// What this block does
// R01 - master sends word address after device address; device acknowledges it low
// R02 - after word address acknowledge, device shifts in the 8-bit data byte
// R03 - byte write: master ends with stop after the data byte acknowledge
// R04 - stop after a write starts timed write cycle; bus ignored meanwhile
// R05 - page is 8 bytes for 2K, 16 bytes for larger capacities
// R06 - page write: master sends up to page-size bytes then a stop
// R07 - device acknowledges every data byte of a page write with low
// R08 - page write increments only the low page bits; address wraps in page
// R09 - more bytes than a page overwrite earlier bytes of the transaction
// R10 - master polls with start plus device address carrying intended direction
// R11 - polling address acknowledged only after the write cycle has ended
// R12 - read/write bit one selects read, otherwise transaction runs as write
// R13 - address counter holds last address plus one, kept between transactions
// R14 - read address wraps from last array byte to first array byte
// R15 - current address read shifts out byte at counter address
// R16 - master ends single read with no acknowledge then stop
// R17 - random read: dummy write of addresses, then repeated start and read
// R18 - random read shifts out byte at word address of the dummy write
// R19 - master acknowledges each read byte it wants followed by another
// R20 - acknowledged read byte: increment address, shift out the next byte
// R21 - master ends sequential read with no acknowledge then stop
// R22 - write cycle finishes within 5 ms of the stop
// R23 - high read/write bit is read, low is write
// R24 - page-select bits of device address become word address top bits
// R25 - device address top four bits are the fixed one-zero-one-zero pattern
// R26 - after master withholds acknowledge, device releases data until next start
`default_nettype none
package eeprom_pkg;

   localparam int          ADDR_W_DEF   = 11;
   localparam int          BYTE_W       = 8;
   localparam int          SEL_MAX      = 3;
   localparam int          PAGE_MAX     = 16;
   localparam logic [3:0]  FAMILY_CODE  = 4'hA;
   localparam logic [2:0]  LAST_BIT     = 3'h7;
   localparam int          MCLK_HZ      = 10_000_000;
   localparam int          NVM_WR_MS    = 5;
   // longest time: rounded down to whole cycles
   localparam int          NVM_WR_CYC   = MCLK_HZ / 1000 * NVM_WR_MS;

   typedef enum logic [8:0] {
      ST_IDLE      = 9'h001,
      ST_DEV       = 9'h002,
      ST_DEV_ACK   = 9'h004,
      ST_WADDR     = 9'h008,
      ST_WADDR_ACK = 9'h010,
      ST_WDATA     = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA     = 9'h080,
      ST_RACK      = 9'h100
   } link_state_t;

   typedef struct packed {
      logic sda_out;
      logic sda_oe;
   } sda_pin_t;

   function automatic int page_bits(input int addr_w);
      return (addr_w == 8) ? 3 : 4;
   endfunction : page_bits

endpackage : eeprom_pkg
`default_nettype wire

// file: hw/nvm_write_timer.sv
`default_nettype none
module nvm_write_timer #(
   parameter int CYCLES = eeprom_pkg::NVM_WR_CYC
) (
   // clock and reset
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   // control
   input  wire logic i_go,
   output logic      o_busy,
   output logic      o_done
);
   import eeprom_pkg::*;

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          busy_r;
   logic          busy_nxt;
   logic          done_r;
   logic          done_nxt;

   always_comb
   begin
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (busy_r)
      begin
         if (cnt_r == LAST) // R22
         begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
         else
         begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
      else if (i_go)
      begin
         busy_nxt = 1'b1;
         cnt_nxt  = '0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign o_busy = busy_r;
   assign o_done = done_r;

endmodule : nvm_write_timer
`default_nettype wire

// file: hw/serial_eeprom_rw_engine.sv
`default_nettype none
module serial_eeprom_rw_engine #(
   parameter int ADDR_W = eeprom_pkg::ADDR_W_DEF,
   parameter int WR_CYC = eeprom_pkg::NVM_WR_CYC
) (
   // core clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   // two-wire link, clocked by the serial clock except i_bus_idle, which is sampled on the core clock
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   input  wire logic       i_bus_start,
   input  wire logic       i_bus_idle,
   output logic            o_sda_out,
   output logic            o_sda_oe,
   // strapped chip-select pins
   input  wire logic [2:0] i_chip_sel,
   // status
   output logic            o_write_busy
);
   import eeprom_pkg::*;

   localparam int PB    = page_bits(ADDR_W); // R05
   localparam int PAGE  = 1 << PB;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int SEL_W = ADDR_W - BYTE_W;
   localparam logic [2:0] CMP_MASK = 3'(3'h7 << SEL_W);

   // array lives in the core domain; link reads it only while no commit runs
   logic [BYTE_W-1:0] mem [DEPTH];
   // link-domain state
   link_state_t       st_r, st_nxt;
   logic [2:0]        cnt_r, cnt_nxt;
   logic [BYTE_W-1:0] shf_r, shf_nxt;
   logic [BYTE_W-1:0] tx_r, tx_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [2:0]        sel_r, sel_nxt;
   logic              rw_r, rw_nxt;
   logic              wr_req_r, wr_req_nxt;
   logic [PAGE-1:0]   vld_r, vld_nxt;
   logic [BYTE_W-1:0] pbuf_r [PAGE];
   logic [BYTE_W-1:0] pbuf_nxt [PAGE];
   sda_pin_t          pin_r, pin_nxt;
   // link-side synchronisers
   logic [2:0]        cs_m, cs_s;
   logic              done_m, done_s;
   // core-domain state, then link-side helper nets
   logic              req_m, req_s;
   logic              idle_m, idle_s, idle_d;
   logic              ack_r, ack_nxt;
   logic              go;
   logic              t_busy, t_done;
   logic              wbusy_r;
   logic [BYTE_W-1:0] rbyte, rbyte_inc;
   logic [BYTE_W-1:0] shf_in;
   logic              busy_link;
   logic [ADDR_W-1:0] addr_inc, waddr;

   assign shf_in    = {shf_r[BYTE_W-2:0], i_sda};
   assign addr_inc  = addr_r + 1'b1;
   assign rbyte     = mem[addr_r];
   assign rbyte_inc = mem[addr_inc];
   assign waddr     = ADDR_W'({sel_r, shf_in});
   // a commit is pending until the core side reports it finished
   assign busy_link = wr_req_r & ~done_s;

   always_comb
   begin
      st_nxt     = st_r;
      cnt_nxt    = cnt_r + 1'b1;
      shf_nxt    = shf_in;
      tx_nxt     = tx_r;
      addr_nxt   = addr_r;
      sel_nxt    = sel_r;
      rw_nxt     = rw_r;
      vld_nxt    = vld_r;
      wr_req_nxt = wr_req_r & ~done_s;
      for (int i = 0; i < PAGE; i++)
      begin
         pbuf_nxt[i] = pbuf_r[i];
      end
      if (i_bus_start)
      begin
         st_nxt  = ST_DEV;
         cnt_nxt = 3'h1;
         shf_nxt = {{(BYTE_W-1){1'b0}}, i_sda};
      end
      else
      begin
         case (st_r)
            ST_IDLE:
            begin
               cnt_nxt = '0;
            end
            ST_DEV:
            begin
               if (cnt_r == LAST_BIT)
               begin
                  // R25 R11 R04
                  if (shf_in[7:4] == FAMILY_CODE && !busy_link
                      && ((shf_in[3:1] ^ cs_s) & CMP_MASK) == 3'h0)
                  begin
                     st_nxt  = ST_DEV_ACK;
                     rw_nxt  = shf_in[0]; // R12 R23
                     sel_nxt = shf_in[3:1] & ~CMP_MASK; // R24
                  end
                  else
                  begin
                     st_nxt = ST_IDLE;
                  end
               end
            end
            ST_DEV_ACK:
            begin
               cnt_nxt = '0;
               if (rw_r)
               begin
                  st_nxt = ST_RDATA;
                  tx_nxt = rbyte; // R15 R18
               end
               else
               begin
                  st_nxt = ST_WADDR; // R01
               end
            end
            ST_WADDR:
            begin
               if (cnt_r == LAST_BIT)
               begin
                  st_nxt   = ST_WADDR_ACK; // R01
                  addr_nxt = waddr;
                  vld_nxt  = '0;
               end
            end
            ST_WADDR_ACK:
            begin
               cnt_nxt = '0;
               st_nxt  = ST_WDATA; // R02
            end
            ST_WDATA:
            begin
               if (cnt_r == LAST_BIT)
               begin
                  st_nxt = ST_WDATA_ACK; // R07
                  // later bytes overwrite earlier ones in the same slot
                  pbuf_nxt[addr_r[PB-1:0]] = shf_in; // R09
                  vld_nxt[addr_r[PB-1:0]]  = 1'b1;
                  wr_req_nxt = 1'b1; // R04
                  addr_nxt = {addr_r[ADDR_W-1:PB],
                              PB'(addr_r[PB-1:0] + 1'b1)}; // R08 R13
               end
            end
            ST_WDATA_ACK:
            begin
               cnt_nxt = '0;
               st_nxt  = ST_WDATA;
            end
            ST_RDATA:
            begin
               if (cnt_r == LAST_BIT)
               begin
                  st_nxt = ST_RACK;
               end
            end
            ST_RACK:
            begin
               cnt_nxt  = '0;
               addr_nxt = addr_inc; // R13 R14
               if (!i_sda)
               begin
                  st_nxt = ST_RDATA; // R20
                  tx_nxt = rbyte_inc;
               end
               else
               begin
                  st_nxt = ST_IDLE; // R26
               end
            end
            default:
            begin
               st_nxt = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_scl or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_r     <= ST_IDLE;
         cnt_r    <= '0;
         shf_r    <= '0;
         tx_r     <= '0;
         addr_r   <= '0;
         sel_r    <= '0;
         rw_r     <= 1'b0;
         wr_req_r <= 1'b0;
         vld_r    <= '0;
         cs_m     <= '0;
         cs_s     <= '0;
         done_m   <= 1'b0;
         done_s   <= 1'b0;
      end
      else
      begin
         st_r     <= st_nxt;
         cnt_r    <= cnt_nxt;
         shf_r    <= shf_nxt;
         tx_r     <= tx_nxt;
         addr_r   <= addr_nxt;
         sel_r    <= sel_nxt;
         rw_r     <= rw_nxt;
         wr_req_r <= wr_req_nxt;
         vld_r    <= vld_nxt;
         cs_m     <= i_chip_sel;
         cs_s     <= cs_m;
         done_m   <= ack_r;
         done_s   <= done_m;
      end
   end

   // page buffer carries data only, so it needs no reset
   always_ff @(posedge i_scl)
   begin
      for (int i = 0; i < PAGE; i++)
      begin
         pbuf_r[i] <= pbuf_nxt[i];
      end
   end

   // data line changes on the falling edge so it is steady while scl is high
   always_comb
   begin
      pin_nxt.sda_out = 1'b0;
      case (st_r)
         ST_DEV_ACK, ST_WADDR_ACK, ST_WDATA_ACK:
         begin
            pin_nxt.sda_oe = 1'b1; // R01 R07 R11
         end
         ST_RDATA:
         begin
            pin_nxt.sda_oe = ~tx_r[LAST_BIT - cnt_r]; // R15 R20
         end
         default:
         begin
            pin_nxt.sda_oe = 1'b0; // R26
         end
      endcase
   end

   always_ff @(negedge i_scl or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pin_r <= '0;
      end
      else
      begin
         pin_r <= pin_nxt;
      end
   end

   assign o_sda_out = pin_r.sda_out;
   assign o_sda_oe  = pin_r.sda_oe;

   // core side: 4-phase handshake on wr_req_r / ack_r
   // write cycle starts on the stop that leaves the bus idle
   assign go = idle_s & ~idle_d & req_s & ~ack_r & ~t_busy; // R04
   always_comb
   begin
      ack_nxt = ack_r;
      if (t_done)
      begin
         ack_nxt = 1'b1;
      end
      else if (!req_s)
      begin
         ack_nxt = 1'b0;
      end
   end
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         req_m   <= 1'b0;
         req_s   <= 1'b0;
         idle_m  <= 1'b0;
         idle_s  <= 1'b0;
         idle_d  <= 1'b0;
         ack_r   <= 1'b0;
         wbusy_r <= 1'b0;
      end
      else
      begin
         req_m   <= wr_req_r;
         req_s   <= req_m;
         idle_m  <= i_bus_idle;
         idle_s  <= idle_m;
         idle_d  <= idle_s;
         ack_r   <= ack_nxt;
         wbusy_r <= t_busy | go;
      end
   end
   assign o_write_busy = wbusy_r;

   // go cycle is the first busy cycle, so the timer runs one short
   nvm_write_timer #(
      .CYCLES ((WR_CYC > 1) ? WR_CYC - 1 : 1) // R22
   ) u_timer (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_go    (go),
      .o_busy  (t_busy),
      .o_done  (t_done)
   );

   // buffer and page row are frozen while the link refuses the bus
   always_ff @(posedge i_mclk)
   begin
      if (t_done)
      begin
         for (int i = 0; i < PAGE; i++)
         begin
            if (vld_r[i])
            begin
               mem[{addr_r[ADDR_W-1:PB], PB'(i)}] <= pbuf_r[i]; // R22
            end
         end
      end
   end

endmodule : serial_eeprom_rw_engine
`default_nettype wire

// file: tb/eeprom_chk_properties.sv
`default_nettype none
module eeprom_chk #(
   parameter int WR_CYC = 20
) (
   // clocks and reset
   input wire logic       i_mclk,
   input wire logic       i_rst_n,
   input wire logic       i_scl,
   // link and status
   input wire logic       i_sda,
   input wire logic       i_bus_start,
   input wire logic       i_bus_idle,
   input wire logic       o_sda_out,
   input wire logic       o_sda_oe,
   input wire logic [2:0] i_chip_sel,
   input wire logic       o_write_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0]  n_nxt, n_r;
   logic [7:0]  dev_nxt, dev_r;
   logic        ack_nxt, ack_r, nak_nxt, nak_r, slot, wr, rd;
   logic [15:0] cnt_nxt, cnt_r;
   // edge number in frame, saturating so long bursts stay harmless
   always_comb
   begin
      n_nxt   = i_bus_start ? 9'h001 : n_r + {8'h00, n_r != 9'h1FF};
      slot    = n_nxt % 9'h009 == 9'h000 && n_nxt > 9'h009;
      dev_nxt = n_nxt < 9'h009 ? {dev_r[6:0], i_sda} : dev_r;
      ack_nxt = n_nxt == 9'h009 ? o_sda_oe : ack_r && !i_bus_start;
      wr      = ack_r && !dev_r[0];
      rd      = ack_r && dev_r[0];
      nak_nxt = !i_bus_start && (nak_r || slot && rd && i_sda);
   end
   always_ff @(posedge i_scl or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         n_r   <= 9'h000;
         dev_r <= 8'h00;
         ack_r <= 1'b0;
         nak_r <= 1'b0;
      end
      else
      begin
         n_r   <= n_nxt;
         dev_r <= dev_nxt;
         ack_r <= ack_nxt;
         nak_r <= nak_nxt;
      end
   end
   always_comb
   begin
      cnt_nxt = o_write_busy ? cnt_r + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_r <= 16'h0000;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end
   property p_family;
      @(posedge i_scl) disable iff (!i_rst_n)
      n_nxt == 9'h009 && dev_r[7:4] != 4'hA |-> !o_sda_oe;
   endproperty
   a_family: assert property (p_family)
      else $error("foreign family acknowledged");
   property p_word_ack;
      @(posedge i_scl) disable iff (!i_rst_n)
      n_nxt == 9'h012 && wr |-> o_sda_oe ##1 !o_sda_oe;
   endproperty
   a_word_ack: assert property (p_word_ack)
      else $error("word address ack wrong");
   property p_wr_rx;
      @(posedge i_scl) disable iff (!i_rst_n)
      wr && n_nxt > 9'h009 && !slot |-> !o_sda_oe;
   endproperty
   a_wr_rx: assert property (p_wr_rx)
      else $error("line driven while receiving");
   property p_data_ack;
      @(posedge i_scl) disable iff (!i_rst_n)
      wr && slot && n_nxt > 9'h012 |-> o_sda_oe;
   endproperty
   a_data_ack: assert property (p_data_ack)
      else $error("data byte not acknowledged");
   property p_rd_slot;
      @(posedge i_scl) disable iff (!i_rst_n)
      rd && slot |-> !o_sda_oe;
   endproperty
   a_rd_slot: assert property (p_rd_slot)
      else $error("line held in master ack slot");
   // the link clock stops after a nack, so watch the line on the core clock
   property p_nak;
      @(posedge i_mclk) disable iff (!i_rst_n)
      nak_r && !i_bus_start |-> !o_sda_oe;
   endproperty
   a_nak: assert property (p_nak)
      else $error("line driven after master nack");
   property p_busy_len;
      @(posedge i_mclk) disable iff (!i_rst_n)
      $fell(o_write_busy) |-> cnt_r == 16'(WR_CYC);
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("write cycle length wrong");
   property p_busy_quiet;
      @(posedge i_mclk) disable iff (!i_rst_n)
      o_write_busy |-> !o_sda_oe && !o_sda_out;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("response during write cycle");
   c_nak: cover property (@(posedge i_mclk) nak_r);
   c_page: cover property (@(posedge i_scl) wr && n_nxt == 9'h0B4);
   c_commit: cover property (@(posedge i_mclk) $fell(o_write_busy));
endmodule : eeprom_chk
bind serial_eeprom_rw_engine eeprom_chk #(.WR_CYC(WR_CYC)) eeprom_chk_inst (
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
   .i_bus_start(i_bus_start), .i_bus_idle(i_bus_idle),
   .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_chip_sel(i_chip_sel),
   .o_write_busy(o_write_busy)
);
`default_nettype wire

// file: tb/bus_master_model.sv
`default_nettype none
module bus_master_model (
   // link outputs
   output logic      o_scl,
   output logic      o_sda,
   output logic      o_start,
   output logic      o_idle,
   // resolved line
   input  wire logic i_line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      o_scl   = 1'b0;
      o_sda   = 1'b1;
      o_start = 1'b0;
      o_idle  = 1'b1;
   end
   // clock stands low between frames, so no stray edge reaches the link
   task bit_io(input logic b, input logic st, output logic s);
      o_sda   = b;
      o_start = st;
      o_idle  = o_idle && !st;
      #16;
      o_scl = 1'b1;
      s     = i_line;
      #32;
      o_scl   = 1'b0;
      o_start = 1'b0;
      #16;
   endtask : bit_io
   task send(input logic [7:0] b, input logic st, output logic ak);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(b[i], st && i == 7, s);
      end
      bit_io(1'b1, 1'b0, s);
      ak = !s;
   endtask : send
   task recv(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, 1'b0, s);
         d[i] = s;
      end
      bit_io(!more, 1'b0, s);
   endtask : recv
   task stop();
      o_sda  = 1'b1;
      o_idle = 1'b1;
      #500;
   endtask : stop
endmodule : bus_master_model
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         error_cnt++; \
         $display("ERROR %s exp %h seen %h", nm, e, g); \
      end \
   end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_mclk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic [2:0]  i_chip_sel = 3'b101;
   logic        scl, sda_m, bstart, bidle, oe, sout, k;
   wire logic   line = oe ? sout : sda_m;
   logic [7:0]  mem [512];
   logic [8:0]  cur, a9;
   logic [31:0] seed = 32'hBA8C430C;
   int          error_cnt = 0;
   int          num_checks = 0;
   always #50 i_mclk = ~i_mclk;
   serial_eeprom_rw_engine #(.ADDR_W(9), .WR_CYC(20))
   serial_eeprom_rw_engine_inst (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(line),
      .i_bus_start(bstart), .i_bus_idle(bidle), .o_sda_out(sout),
      .o_sda_oe(oe), .i_chip_sel(i_chip_sel), .o_write_busy()
   );
   bus_master_model bus_master_model_inst (
      .o_scl(scl), .o_sda(sda_m), .o_start(bstart), .o_idle(bidle),
      .i_line(line)
   );
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [7:0] dev(logic [8:0] a, logic rw);
      return {4'hA, i_chip_sel[2:1], a[8], rw};
   endfunction : dev
   task wr(input logic [8:0] a, input int n);
      logic [7:0] d;
      bus_master_model_inst.send(dev(a, 1'b0), 1'b1, k);
      `CHK("dev ack", 1'b1, k)
      bus_master_model_inst.send(a[7:0], 1'b0, k);
      `CHK("word ack", 1'b1, k)
      for (int i = 0; i < n; i++)
      begin
         d = 8'(rnd());
         bus_master_model_inst.send(d, 1'b0, k);
         `CHK("data ack", 1'b1, k)
         mem[a] = d;
         a = {a[8:4], a[3:0] + 4'h1};
      end
      cur = a;
      bus_master_model_inst.stop();
      bus_master_model_inst.send(dev(a, 1'b0), 1'b1, k);
      `CHK("early poll", 1'b0, k)
      bus_master_model_inst.stop();
      for (int j = 0; j < 40 && !k; j++)
      begin
         bus_master_model_inst.send(dev(a, 1'b0), 1'b1, k);
         bus_master_model_inst.stop();
      end
      `CHK("poll done", 1'b1, k)
      if (!k)
      begin
         wrap_up();
      end
   endtask : wr
   task rd(input logic [8:0] a, input logic dummy, input int n);
      logic [7:0] d;
      if (dummy)
      begin
         bus_master_model_inst.send(dev(a, 1'b0), 1'b1, k);
         bus_master_model_inst.send(a[7:0], 1'b0, k);
         cur = a;
      end
      bus_master_model_inst.send(dev(cur, 1'b1), 1'b1, k);
      `CHK("read ack", 1'b1, k)
      for (int i = 0; i < n; i++)
      begin
         bus_master_model_inst.recv(i < n - 1, d);
         `CHK("read data", mem[cur], d)
         cur = cur + 9'h001;
      end
      bus_master_model_inst.stop();
   endtask : rd
   task wrap_up();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (2) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      for (int t = 0; t < 3; t++)
      begin
         a9 = 9'(rnd());
         wr(a9, 1);
         rd(a9, 1'b1, 1);
      end
      // 18 bytes from offset 14 wrap inside the page and overwrite
      wr(9'h00E, 18);
      wr(9'h1FF, 1);
      rd(9'h00E, 1'b1, 1);
      rd(cur, 1'b0, 1);
      // read across the array end back to the first page
      rd(9'h1FF, 1'b1, 17);
      bus_master_model_inst.send(8'h51, 1'b1, k);
      `CHK("foreign family", 1'b0, k)
      bus_master_model_inst.stop();
      bus_master_model_inst.send({4'hA, ~i_chip_sel[2:1], 2'b01}, 1'b1, k);
      `CHK("strap mismatch", 1'b0, k)
      bus_master_model_inst.stop();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
